//--- rwa_word_aligner.sv
// Receive word aligner: restores the word boundary from a pattern
//
// How it works
// - Shift incoming words so output boundary sits where the pattern was seen.
// - Three modes selectable: manual alignment, bit-slip, automatic sync machine.
// - Manual and bit-slip: 16-bit pattern at 8-bit width, 7/10 at 10-bit.
// - Automatic sync machine works only at 10-bit width, 7 or 10-bit pattern.
// - In manual mode fabric steers alignment only by the enable input.
// - Manual 8-bit mode reacts to enable edges, never to its level.
// - Fabric raises enable after digital reset; each rising edge starts a search.
// - Active search moves boundary when pattern appears at a different boundary.
// - 8-bit: after boundary set, other positions ignored until next rising edge.
// - Manual 10-bit mode treats the enable input as a level.
// - 10-bit with enable high: search pattern and its bitwise complement.
// - 10-bit with enable low: boundary held even if pattern moves.
`timescale 1ns/1ps
`default_nettype none
`include "rwa_consts.svh"

module rwa_word_aligner
   import rwa_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        rx_digital_rst,
   // Configuration and control from fabric
   input  wire rwa_cfg_s    cfg,
   input  wire logic        align_en,
   input  wire logic        bitslip,
   // Deserializer words
   input  wire logic [9:0]  rx_parallel,
   // Aligned words and status
   output logic      [9:0]  rx_aligned,
   output logic             pattern_detect,
   output logic             sync_status,
   output logic      [3:0]  boundary
);

   rwa_state_s q;
   rwa_state_s d;

   logic [19:0] win10;
   logic [25:0] win8;
   logic [9:0]  match;
   logic        hit;
   logic [3:0]  hit_k;
   logic        cur_hit;
   logic        other_hit;
   logic        en_rise;
   logic        slip_rise;
   logic [3:0]  max_off;

   // Oldest bit sits at bit 0; slices walk toward newer data
   assign win10 = {rx_parallel, q.prev1};
   assign win8  = {2'h0, rx_parallel[7:0], q.prev1[7:0], q.prev2[7:0]};

   genvar k;
   generate
      for (k = 0; k < 10; k++) begin : g_pos
         logic m10;
         logic m7;
         logic m8;
         always_comb begin
            m10 = (win10[k +: 10] == cfg.pattern[9:0]) ||
                  (win10[k +: 10] == ~cfg.pattern[9:0]);
            m7  = (win10[k +: 7] == cfg.pattern[6:0]) ||
                  (win10[k +: 7] == ~cfg.pattern[6:0]);
            m8  = (k < `RWA_W8) &&
                  (win8[k +: `RWA_PAT8_LEN] == cfg.pattern);
         end
         assign match[k] = cfg.width10 ? (cfg.pat_len10 ? m10 : m7)
                                       : m8;
      end
   endgenerate

   // Lowest matching position wins when several line up
   always_comb begin
      hit   = 1'b0;
      hit_k = `RWA_RST_OFF;
      for (int i = 9; i >= 0; i--) begin
         if (match[i]) begin
            hit   = 1'b1;
            hit_k = 4'(i);
         end
      end
   end

   assign cur_hit   = match[q.off];
   assign other_hit = hit && (hit_k != q.off);
   assign en_rise   = align_en && !q.en_last;
   assign slip_rise = bitslip && !q.slip_last;
   assign max_off   = cfg.width10 ? `RWA_MAX_OFF10 : `RWA_MAX_OFF8;

   always_comb begin
      d           = q;
      d.prev1     = rx_parallel;
      d.prev2     = q.prev1;
      d.en_last   = align_en;
      d.slip_last = bitslip;
      if (cfg.width10) begin
         d.word = win10[q.off +: 10];
      end else begin
         d.word = {2'h0, win8[q.off +: 8]};
      end
      d.pdet = cur_hit;

      if (rx_digital_rst) begin
         // Edge tracking follows the pin so a level held through reset
         // is not mistaken for a fresh rising edge
         d.armed = 1'b0;
         d.fsm   = RWA_SYNC_LOSS;
         d.cnt   = 3'h0;
         d.sync  = 1'b0;
         d.pdet  = 1'b0;
      end else begin
         unique case (cfg.mode)
            RWA_MODE_MANUAL: begin
               d.fsm  = RWA_SYNC_LOSS;
               d.sync = 1'b0;
               if (!cfg.width10) begin
                  if (en_rise) begin
                     d.armed = 1'b1;
                  end
                  if (q.armed && hit) begin
                     d.off   = hit_k;
                     d.armed = 1'b0;
                  end
               end else begin
                  d.armed = 1'b0;
                  if (align_en && other_hit) begin
                     d.off = hit_k;
                  end
               end
            end
            RWA_MODE_BITSLIP: begin
               d.armed = 1'b0;
               d.fsm   = RWA_SYNC_LOSS;
               d.sync  = 1'b0;
               if (slip_rise) begin
                  d.off = (q.off >= max_off) ? `RWA_RST_OFF
                                             : q.off + 4'h1;
               end
            end
            RWA_MODE_AUTO: begin
               d.armed = 1'b0;
               // Only legal at 10-bit width; 8-bit holds in loss
               if (!cfg.width10) begin
                  d.fsm  = RWA_SYNC_LOSS;
                  d.cnt  = 3'h0;
                  d.sync = 1'b0;
               end else begin
                  unique case (q.fsm)
                     RWA_SYNC_LOSS: begin
                        if (hit) begin
                           d.off = hit_k;
                           d.cnt = 3'h1;
                           d.fsm = RWA_SYNC_ACQ;
                        end
                     end
                     RWA_SYNC_ACQ: begin
                        if (other_hit) begin
                           d.off = hit_k;
                           d.cnt = 3'h1;
                        end else if (cur_hit) begin
                           d.cnt = q.cnt + 3'h1;
                           if (q.cnt + 3'h1 >= `RWA_GOOD_TO_SYNC) begin
                              d.fsm  = RWA_SYNC_LOCK;
                              d.cnt  = 3'h0;
                              d.sync = 1'b1;
                           end
                        end
                     end
                     RWA_SYNC_LOCK: begin
                        // Stray patterns must repeat before sync drops
                        if (other_hit) begin
                           d.cnt = q.cnt + 3'h1;
                           if (q.cnt + 3'h1 >= `RWA_BAD_TO_LOSS) begin
                              d.fsm  = RWA_SYNC_LOSS;
                              d.cnt  = 3'h0;
                              d.sync = 1'b0;
                           end
                        end else if (cur_hit) begin
                           d.cnt = 3'h0;
                        end
                     end
                     default: begin
                        d.fsm  = RWA_SYNC_LOSS;
                        d.cnt  = 3'h0;
                        d.sync = 1'b0;
                     end
                  endcase
               end
            end
            default: begin
               d.armed = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         q.prev1     <= `RWA_RST_WORD;
         q.prev2     <= `RWA_RST_WORD;
         q.en_last   <= 1'b0;
         q.slip_last <= 1'b0;
         q.armed     <= 1'b0;
         q.off       <= `RWA_RST_OFF;
         q.fsm       <= RWA_SYNC_LOSS;
         q.cnt       <= 3'h0;
         q.word      <= `RWA_RST_WORD;
         q.pdet      <= 1'b0;
         q.sync      <= 1'b0;
      end else begin
         q <= d;
      end
   end

   assign rx_aligned     = q.word;
   assign pattern_detect = q.pdet;
   assign sync_status    = q.sync;
   assign boundary       = q.off;

endmodule
`default_nettype wire

//--- rwa_consts.svh
// Constants for the receive word aligner
`ifndef RWA_CONSTS_SVH
`define RWA_CONSTS_SVH

`define RWA_W10          10
`define RWA_W8           8
`define RWA_PAT8_LEN     16
`define RWA_MAX_OFF10    4'h9
`define RWA_MAX_OFF8     4'h7
`define RWA_GOOD_TO_SYNC 3'h3
`define RWA_BAD_TO_LOSS  3'h4
`define RWA_RST_OFF      4'h0
`define RWA_RST_WORD     10'h000

`endif

//--- rwa_pkg.sv
// Types shared by the receive word aligner
package rwa_pkg;

   typedef enum logic [1:0] {
      RWA_MODE_MANUAL  = 2'h0,
      RWA_MODE_BITSLIP = 2'h1,
      RWA_MODE_AUTO    = 2'h2
   } rwa_mode_e;

   typedef enum logic [2:0] {
      RWA_SYNC_LOSS = 3'b001,
      RWA_SYNC_ACQ  = 3'b010,
      RWA_SYNC_LOCK = 3'b100
   } rwa_sync_e;

   // Configuration coming from the fabric side
   typedef struct packed {
      rwa_mode_e   mode;
      logic        width10;
      logic        pat_len10;
      logic [15:0] pattern;
   } rwa_cfg_s;

   typedef struct packed {
      logic [9:0]  prev1;
      logic [9:0]  prev2;
      logic        en_last;
      logic        slip_last;
      logic        armed;
      logic [3:0]  off;
      rwa_sync_e   fsm;
      logic [2:0]  cnt;
      logic [9:0]  word;
      logic        pdet;
      logic        sync;
   } rwa_state_s;

endpackage

//--- rwa_deser_model.sv
// Deserializer model: periodic stream with the pattern at bit k
`timescale 1ns/1ps
`default_nettype none
module rwa_deser_model (
   // Clock
   input  wire logic        clk,
   // Stream shape
   input  wire logic        wide,
   input  wire logic        inv,
   input  wire logic [15:0] pat,
   input  wire logic [3:0]  k,
   // Word out
   output logic      [9:0]  word
);
   logic [4:0] pos_q = 5'h00;
   initial word = 10'h000;
   // Byte stream carries half a pattern per word, so phase is 0 or 8
   always @(posedge clk) begin
      int n;
      n = wide ? 10 : 16;
      for (int i = 0; i < 10; i++)
         word[i] <= (wide || i < 8) ? inv ^ pat[(pos_q + i + n - k) % n] : 1'h0;
      pos_q <= wide ? 5'h00 : pos_q ^ 5'h08;
   end
endmodule
`default_nettype wire

//--- rwa_chk_properties.sv
// Port checks for the word aligner
`timescale 1ns/1ps
`default_nettype none
module rwa_chk
   import rwa_pkg::*;
(
   // Clock and resets
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic       rx_digital_rst,
   // Control
   input wire rwa_cfg_s   cfg,
   input wire logic       align_en,
   input wire logic       bitslip,
   // Results
   input wire logic [9:0] rx_aligned,
   input wire logic       pattern_detect,
   input wire logic       sync_status,
   input wire logic [3:0] boundary
);
   logic [3:0] nx;
   logic       w10;
   assign w10 = cfg.width10;
   // Slip wraps at the top offset of the width
   assign nx = (boundary == (w10 ? 4'h9 : 4'h7)) ? 4'h0 : boundary + 4'h1;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   rst_vals_a: assert property ($rose(rstn) |-> boundary == 4'h0
      && rx_aligned == 10'h000 && !sync_status) else $error("reset value");
   dreset_quiet_a: assert property (rx_digital_rst |=>
      !pattern_detect && !sync_status) else $error("flag in reset");
   dreset_hold_a: assert property (rx_digital_rst &&
      cfg.mode != RWA_MODE_BITSLIP |=> $stable(boundary)) else $error("moved");
   hold_low_a: assert property (cfg.mode == RWA_MODE_MANUAL && w10 &&
      !align_en |=> $stable(boundary)) else $error("moved while low");
   slip_step_a: assert property (cfg.mode == RWA_MODE_BITSLIP &&
      $rose(bitslip) && !rx_digital_rst |=> boundary == $past(nx))
      else $error("bad slip");
   narrow_auto_a: assert property ((cfg.mode == RWA_MODE_AUTO && !w10)[*3]
      |-> !sync_status) else $error("sync at byte width");
   upper_zero_a: assert property (!w10 |=> rx_aligned[9:8] == 2'h0)
      else $error("upper bits set");
   mode_idle_a: assert property (cfg.mode == rwa_mode_e'(2'h3) |=>
      $stable(boundary)) else $error("moved in idle mode");
   cover property (sync_status);
   cover property ($rose(pattern_detect));
   cover property (w10 && align_en && $changed(boundary));
endmodule
bind rwa_word_aligner rwa_chk chk_u (.clk(clk), .rstn(rstn), .cfg(cfg),
   .rx_digital_rst(rx_digital_rst), .align_en(align_en), .bitslip(bitslip),
   .rx_aligned(rx_aligned), .pattern_detect(pattern_detect),
   .sync_status(sync_status), .boundary(boundary));
`default_nettype wire

//--- tb_top.sv
// Directed bench for the word aligner
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import rwa_pkg::*;
;
   localparam rwa_mode_e MAN = RWA_MODE_MANUAL;
   logic       clk, rstn, drst, en, slip, wide, inv, pdet, sync;
   logic [3:0] k, bnd;
   logic [9:0] word, outw;
   rwa_cfg_s   cfg;
   int         err_total = 0, checks = 0, ticks = 0;
   rwa_word_aligner dut_u (.clk(clk), .rstn(rstn), .rx_digital_rst(drst),
      .cfg(cfg), .align_en(en), .bitslip(slip), .rx_parallel(word),
      .rx_aligned(outw), .pattern_detect(pdet), .sync_status(sync),
      .boundary(bnd));
   rwa_deser_model model_u (.clk(clk), .wide(wide), .inv(inv),
      .pat(cfg.pattern), .k(k), .word(word));
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Apply a setting, then give the boundary time to settle
   task automatic apply(input rwa_mode_e m, input logic w, e,
                        input logic [3:0] p, input logic v);
      @(posedge clk);
      cfg.mode <= m;
      cfg.width10 <= w;
      wide <= w;
      en <= e;
      k <= p;
      inv <= v;
      repeat (7) @(posedge clk);
      #1;
   endtask
   task automatic close_out;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk) begin
      ticks <= ticks + 1;
      if (ticks == 1000) begin
         err_total++;
         close_out();
      end
   end
   initial begin
      {rstn, drst, en, slip, inv, wide, k} = 10'h010;
      cfg = '{MAN, 1'h1, 1'h1, 16'hc17c};
      repeat (8) @(posedge clk);
      #1;
      chk(outw, 10'h000);
      @(posedge clk) rstn <= 1'h1;
      apply(MAN, 1'h1, 1'h1, 4'h3, 1'h0);
      chk(10'(bnd), 10'h003);
      chk(outw, 10'h17c);
      chk(10'(pdet), 10'h001);
      apply(MAN, 1'h1, 1'h0, 4'h6, 1'h0);
      chk(10'(bnd), 10'h003);
      apply(MAN, 1'h1, 1'h1, 4'h6, 1'h0);
      chk(10'(bnd), 10'h006);
      apply(MAN, 1'h1, 1'h1, 4'h2, 1'h1);
      chk(10'(bnd), 10'h002);
      chk(outw, 10'h283);
      apply(MAN, 1'h0, 1'h0, 4'h5, 1'h0);
      chk(10'(bnd), 10'h002);
      apply(MAN, 1'h0, 1'h1, 4'h5, 1'h0);
      chk(10'(bnd), 10'h005);
      apply(MAN, 1'h0, 1'h1, 4'h1, 1'h0);
      chk(10'(bnd), 10'h005);
      apply(MAN, 1'h0, 1'h0, 4'h1, 1'h0);
      apply(MAN, 1'h0, 1'h1, 4'h1, 1'h0);
      chk(10'(bnd), 10'h001);
      @(posedge clk) drst <= 1'h1;
      apply(MAN, 1'h1, 1'h1, 4'h4, 1'h0);
      chk(10'(bnd), 10'h001);
      chk(10'(pdet), 10'h000);
      @(posedge clk) drst <= 1'h0;
      apply(MAN, 1'h1, 1'h1, 4'h4, 1'h0);
      chk(10'(bnd), 10'h004);
      apply(RWA_MODE_BITSLIP, 1'h1, 1'h0, 4'h4, 1'h0);
      repeat (6) begin
         @(posedge clk) slip <= 1'h1;
         @(posedge clk) slip <= 1'h0;
      end
      apply(RWA_MODE_BITSLIP, 1'h1, 1'h0, 4'h4, 1'h0);
      chk(10'(bnd), 10'h000);
      apply(rwa_mode_e'(2'h3), 1'h1, 1'h1, 4'h7, 1'h0);
      chk(10'(bnd), 10'h000);
      apply(RWA_MODE_AUTO, 1'h1, 1'h0, 4'h7, 1'h0);
      chk(10'(sync), 10'h001);
      chk(10'(bnd), 10'h007);
      apply(RWA_MODE_AUTO, 1'h0, 1'h0, 4'h7, 1'h0);
      chk(10'(sync), 10'h000);
      // Short pattern: only the low seven bits of the pattern are compared
      @(posedge clk) cfg.pat_len10 <= 1'h0;
      apply(MAN, 1'h1, 1'h1, 4'h6, 1'h0);
      chk(10'(bnd), 10'h006);
      chk(outw, 10'h17c);
      chk(10'(pdet), 10'h001);
      close_out();
   end
endmodule
`default_nettype wire
